//--- logic/rsr_defs.svh
// Purpose: constants for the runtime settings readback block
// Assumes: included by its bare name
// Notes: byte offsets of the register window, report layout, reset values
`ifndef RSR_DEFS_SVH
`define RSR_DEFS_SVH
// ****************************************
// report layout
// ****************************************
`define RSR_CMD_GET 8'h61
`define RSR_STATUS_OK 8'h00
`define RSR_REPORT_LEN 64
`define RSR_BYTE_CMD 0
`define RSR_BYTE_STATUS 1
`define RSR_BYTE_CHIPLEN 2
`define RSR_BYTE_GPLEN 3
`define RSR_BYTE_FLAGS 4
`define RSR_BYTE_CLKDIV 5
// ****************************************
// register window
// ****************************************
`define RSR_OFF_FLAGS 8'h00
`define RSR_OFF_CLKDIV 8'h04
`define RSR_OFF_LENGTHS 8'h08
`define RSR_OFF_PINEN 8'h0c
`define RSR_OFF_STATUS 8'h10
`define RSR_RST_FLAGS 8'h00
`define RSR_RST_CLKDIV 5'h00
`define RSR_RST_CHIPLEN 8'h00
`define RSR_RST_GPLEN 8'h00
`define RSR_RST_PINEN 4'h0
`define RSR_PINEN_CLKOUT 0
`define RSR_PINEN_TWOWIRE 1
`define RSR_PINEN_SUSPEND 2
`define RSR_PINEN_CONFIG 3
`define RSR_RESP_OKAY 2'b00
`define RSR_RESP_SLVERR 2'b10
`endif

//--- logic/rsr_pkg.sv
// Purpose: types of the runtime settings readback block
// Assumes: nothing
// Notes: flags byte layout follows the report, msb first
package rsr_pkg;
	typedef enum logic [1:0] {
		RSR_UNSECURED = 2'b00,
		RSR_PASSWORD = 2'b01,
		RSR_LOCKED = 2'b10,
		RSR_PROT_RSVD = 2'b11
	} rsr_protect_t;
	typedef struct packed {
		logic serialEnable;
		logic rxRest;
		logic txRest;
		logic twowireRest;
		logic suspendRest;
		logic configRest;
		rsr_protect_t protect;
	} rsr_flags_t;
	typedef struct packed {
		logic [1:0] duty;
		logic [2:0] ratio;
	} rsr_clkdiv_t;
	typedef struct packed {
		logic uartRx;
		logic uartTx;
		logic twowire;
		logic suspended;
		logic configured;
	} rsr_activity_t;
	typedef enum logic {RSR_RECV, RSR_SEND} rsr_state_t;
endpackage : rsr_pkg

//--- logic/rsr_readback.sv
// Purpose: settings readback report builder, indicator pins and clock output divider
// Assumes: activity inputs come from logic on clk; registers over AXI4-Lite
// Notes: one request and one response report at a time
`timescale 1ns/1ps
`default_nettype none
`include "rsr_defs.svh"

// Notes on behaviour
// - response byte 0 echoes the readback command code 0x61.
// - response byte 1 is 0x00, meaning the readback succeeded.
// - response byte 2 gives the byte length of the chip settings area.
// - response byte 3 gives the byte length of the pin settings area.
// - flags bit 7 set makes enumeration present the serial number.
// - flags bit 7 clear makes enumeration omit the serial number.
// - the receive indicator rests at flags bit 6 and inverts while receiving.
// - the transmit indicator rests at flags bit 5 and inverts while sending.
// - the two-wire indicator, if enabled, rests at flags bit 4 and inverts on traffic.
// - the suspend indicator, if enabled, rests at flags bit 3 and inverts in suspend.
// - the configured indicator, if enabled, rests at flags bit 2 and inverts once configured.
// - flags bits 1-0 report protection: 10 locked, 01 password, 00 unsecured.
// - with clock output enabled, the pin carries the clock divided by byte 5 bits 4-0.
// - of that setting, bits 4-3 pick the duty cycle and bits 2-0 the ratio.
module rsr_readback
	import rsr_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter int REPORT_LEN = `RSR_REPORT_LEN
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic reqValid,
	input wire logic [7:0] reqData,
	input wire logic reqLast,
	output logic reqReady,
	output logic rspValid,
	output logic [7:0] rspData,
	output logic rspLast,
	input wire logic rspReady,
	input wire rsr_activity_t activity,
	output logic serialNumberEnable,
	output logic rxActivityIndicator,
	output logic txActivityIndicator,
	output logic twowireActivityIndicator,
	output logic suspendIndicator,
	output logic configuredIndicator,
	output logic generalPurposePinClock
);
	localparam int CW = $clog2(REPORT_LEN);
	localparam logic [CW-1:0] LAST_IDX = CW'(REPORT_LEN - 1);

	generate
		if (ADDR_W < 5 || ADDR_W > 32) begin : g_bad_addr
			$error("rsr_readback: ADDR_W must be 5..32");
		end
		if (REPORT_LEN < 8 || (REPORT_LEN & (REPORT_LEN - 1)) != 0) begin : g_bad_len
			$error("rsr_readback: REPORT_LEN must be a power of two, at least 8");
		end
	endgenerate

	// ****************************************
	// decode helpers
	// ****************************************
	// one-hot select: flags, clkdiv, lengths, pinen, status
	function automatic logic [4:0] regSel(input logic [ADDR_W-1:0] a);
		logic [31:0] x;
		logic [7:0] w;
		x = 32'(a);
		w = {x[7:2], 2'b00};
		regSel = 5'h00;
		if (x[31:8] == 24'h000000) begin
			regSel[0] = (w == `RSR_OFF_FLAGS);
			regSel[1] = (w == `RSR_OFF_CLKDIV);
			regSel[2] = (w == `RSR_OFF_LENGTHS);
			regSel[3] = (w == `RSR_OFF_PINEN);
			regSel[4] = (w == `RSR_OFF_STATUS);
		end
	endfunction : regSel

	function automatic logic [7:0] respByte(input logic [CW-1:0] i, input rsr_flags_t f, input rsr_clkdiv_t d,
		input logic [7:0] cl, input logic [7:0] gl);
		case (i)
			CW'(`RSR_BYTE_CMD): respByte = `RSR_CMD_GET;
			CW'(`RSR_BYTE_STATUS): respByte = `RSR_STATUS_OK;
			CW'(`RSR_BYTE_CHIPLEN): respByte = cl;
			CW'(`RSR_BYTE_GPLEN): respByte = gl;
			CW'(`RSR_BYTE_FLAGS): respByte = f;
			CW'(`RSR_BYTE_CLKDIV): respByte = {3'b000, d};
			default: respByte = 8'h00;
		endcase
	endfunction : respByte

	// ****************************************
	// settings registers over AXI4-Lite
	// ****************************************
	rsr_flags_t flags;
	rsr_clkdiv_t clkDiv;
	logic [7:0] chipLen;
	logic [7:0] gpLen;
	logic [3:0] pinEn;
	logic awHave;
	logic wHave;
	logic [ADDR_W-1:0] awAddr;
	logic [31:0] wData;
	logic [3:0] wStrb;

	wire doWrite = awHave & wHave & ~bvalid;
	wire [4:0] wSel = regSel(awAddr);
	wire next_awHave = awHave ? ~doWrite : (awvalid & awready);
	wire next_wHave = wHave ? ~doWrite : (wvalid & wready);
	wire next_bvalid = doWrite | (bvalid & ~bready);
	wire doRead = arvalid & arready;
	wire next_rvalid = doRead | (rvalid & ~rready);
	wire [4:0] rSel = regSel(araddr);
	wire [31:0] statusWord;
	wire [31:0] readMux = ({32{rSel[0]}} & {24'h000000, flags}) |
		({32{rSel[1]}} & {27'h0000000, clkDiv}) |
		({32{rSel[2]}} & {16'h0000, gpLen, chipLen}) |
		({32{rSel[3]}} & {28'h0000000, pinEn}) |
		({32{rSel[4]}} & statusWord);

	always_ff @(posedge clk) begin
		if (!resetn) begin
			awHave <= 1'b0;
			wHave <= 1'b0;
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= `RSR_RESP_OKAY;
			awAddr <= '0;
			wData <= 32'h00000000;
			wStrb <= 4'h0;
		end else begin
			awHave <= next_awHave;
			wHave <= next_wHave;
			awready <= ~next_awHave & ~next_bvalid;
			wready <= ~next_wHave & ~next_bvalid;
			bvalid <= next_bvalid;
			if (awvalid & awready) begin
				awAddr <= awaddr;
			end
			if (wvalid & wready) begin
				wData <= wdata;
				wStrb <= wstrb;
			end
			if (doWrite) begin
				bresp <= (wSel == 5'h00) ? `RSR_RESP_SLVERR : `RSR_RESP_OKAY;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			flags <= `RSR_RST_FLAGS;
			clkDiv <= `RSR_RST_CLKDIV;
			chipLen <= `RSR_RST_CHIPLEN;
			gpLen <= `RSR_RST_GPLEN;
			pinEn <= `RSR_RST_PINEN;
		end else if (doWrite) begin
			if (wSel[0] & wStrb[0]) flags <= wData[7:0];
			if (wSel[1] & wStrb[0]) clkDiv <= wData[4:0];
			if (wSel[2] & wStrb[0]) chipLen <= wData[7:0];
			if (wSel[2] & wStrb[1]) gpLen <= wData[15:8];
			if (wSel[3] & wStrb[0]) pinEn <= wData[3:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= `RSR_RESP_OKAY;
		end else begin
			arready <= ~next_rvalid;
			rvalid <= next_rvalid;
			if (doRead) begin
				rdata <= readMux;
				rresp <= (rSel == 5'h00) ? `RSR_RESP_SLVERR : `RSR_RESP_OKAY;
			end
		end
	end

	// ****************************************
	// request collection and response report
	// ****************************************
	rsr_state_t state;
	logic [CW-1:0] reqCount;
	logic cmdMatch;
	logic [CW-1:0] rspIdx;

	wire reqTake = reqValid & reqReady;
	wire reqDone = reqTake & (reqCount == LAST_IDX);
	wire reqShort = reqTake & reqLast & (reqCount != LAST_IDX);
	wire goSend = reqDone & cmdMatch;
	wire rspTake = rspValid & rspReady;
	wire rspEnd = rspTake & (rspIdx == LAST_IDX);
	wire [CW-1:0] rspNextIdx = rspIdx + CW'(1);
	rsr_state_t next_state;
	assign next_state = (state == RSR_RECV) ? (goSend ? RSR_SEND : RSR_RECV) : (rspEnd ? RSR_RECV : RSR_SEND);

	always_ff @(posedge clk) begin
		if (!resetn) begin
			state <= RSR_RECV;
			reqReady <= 1'b0;
			reqCount <= '0;
			cmdMatch <= 1'b0;
		end else begin
			state <= next_state;
			reqReady <= (next_state == RSR_RECV);
			if (reqDone | reqShort) begin
				reqCount <= '0;
			end else if (reqTake) begin
				reqCount <= reqCount + CW'(1);
			end
			if (reqTake & (reqCount == '0)) begin
				cmdMatch <= (reqData == `RSR_CMD_GET);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			rspValid <= 1'b0;
			rspData <= 8'h00;
			rspLast <= 1'b0;
			rspIdx <= '0;
		end else if (state == RSR_RECV) begin
			rspValid <= goSend;
			rspIdx <= '0;
			rspLast <= 1'b0;
			rspData <= respByte('0, flags, clkDiv, chipLen, gpLen);
		end else if (rspTake) begin
			rspValid <= ~rspEnd;
			rspIdx <= rspNextIdx;
			rspLast <= (rspNextIdx == LAST_IDX);
			rspData <= respByte(rspNextIdx, flags, clkDiv, chipLen, gpLen);
		end
	end

	// ****************************************
	// indicator pins and clock output
	// ****************************************
	logic [9:0] divCount;
	wire clkOutOn = pinEn[`RSR_PINEN_CLKOUT];
	wire [9:0] divPeriod = 10'd4 << clkDiv.ratio;
	wire [9:0] quarter = 10'd1 << clkDiv.ratio;
	// duty 00 and 10 half, 01 quarter, 11 three quarters
	wire [9:0] highLen = (clkDiv.duty == 2'b01) ? quarter :
		(clkDiv.duty == 2'b11) ? (quarter + quarter + quarter) : (quarter + quarter);
	// a shorter period after a rewrite wraps at once
	wire divWrap = (divCount >= divPeriod - 10'd1);

	assign statusWord = {24'h000000, (state == RSR_SEND), rxActivityIndicator, txActivityIndicator,
		twowireActivityIndicator, suspendIndicator, configuredIndicator, generalPurposePinClock, serialNumberEnable};

	always_ff @(posedge clk) begin
		if (!resetn) begin
			divCount <= 10'h000;
			generalPurposePinClock <= 1'b0;
		end else begin
			divCount <= (~clkOutOn | divWrap) ? 10'h000 : divCount + 10'd1;
			generalPurposePinClock <= clkOutOn & (divCount < highLen);
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			serialNumberEnable <= 1'b0;
			rxActivityIndicator <= 1'b0;
			txActivityIndicator <= 1'b0;
			twowireActivityIndicator <= 1'b0;
			suspendIndicator <= 1'b0;
			configuredIndicator <= 1'b0;
		end else begin
			serialNumberEnable <= flags.serialEnable;
			rxActivityIndicator <= flags.rxRest ^ activity.uartRx;
			txActivityIndicator <= flags.txRest ^ activity.uartTx;
			twowireActivityIndicator <= flags.twowireRest ^ (activity.twowire & pinEn[`RSR_PINEN_TWOWIRE]);
			suspendIndicator <= flags.suspendRest ^ (activity.suspended & pinEn[`RSR_PINEN_SUSPEND]);
			configuredIndicator <= flags.configRest ^ (activity.configured & pinEn[`RSR_PINEN_CONFIG]);
		end
	end
endmodule : rsr_readback
`default_nettype wire

//--- verif/rsr_host_model.sv
// Purpose: host side of the report streams
// Assumes: tasks are called just after a clock edge
// Notes: slow makes rspReady toggle every cycle
`timescale 1ns/1ps
`default_nettype none
module rsr_host_model (
	input wire logic clk,
	input wire logic reqReady,
	output logic reqValid,
	output logic [7:0] reqData,
	output logic reqLast,
	input wire logic rspValid,
	input wire logic [7:0] rspData,
	input wire logic rspLast,
	output logic rspReady
);
	// ****
	// request sender and response sink
	// ****
	logic [7:0] got [64];
	int nGot = 0;
	logic slow = 1'b0;
	initial begin
		reqValid = 1'b0;
		reqData = 8'h00;
		reqLast = 1'b0;
		rspReady = 1'b0;
	end
	task automatic send(input logic [7:0] cmd, input int n);
		for (int i = 0; i < n; i++) begin
			reqValid <= 1'b1;
			reqData <= (i == 0) ? cmd : 8'h00;
			reqLast <= (i == n - 1);
			do @(posedge clk); while (reqReady !== 1'b1);
		end
		reqValid <= 1'b0;
		reqLast <= 1'b0;
		reqData <= ~reqData;
		@(posedge clk);
	endtask : send
	always @(posedge clk) begin
		if (rspValid === 1'b1 && rspReady === 1'b1) begin
			got[nGot % 64] <= rspData;
			nGot <= nGot + 1;
		end
		rspReady <= slow ? ~rspReady : 1'b1;
	end
endmodule : rsr_host_model
`default_nettype wire

//--- verif/rsr_readback_chk.sv
// Purpose: port checker of the readback block
// Assumes: one clock, synchronous reset
// Notes: cnt counts response bytes taken
`timescale 1ns/1ps
`default_nettype none
module rsr_readback_chk
	import rsr_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic awready,
	input wire logic reqReady,
	input wire logic rspValid,
	input wire logic [7:0] rspData,
	input wire logic rspLast,
	input wire logic rspReady,
	input wire rsr_activity_t activity,
	input wire logic rxActivityIndicator,
	input wire logic txActivityIndicator
);
	// ****
	// response and indicator properties
	// ****
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	logic [5:0] cnt;
	wire logic take = rspValid && rspReady;
	always_ff @(posedge clk) begin
		if (!resetn) cnt <= 6'h00;
		else if (take) cnt <= rspLast ? 6'h00 : cnt + 6'h01;
	end
	a_cmd_echo: assert property (rspValid && cnt == 6'h00 |-> rspData == 8'h61)
		else $error("byte 0 is not the echo");
	a_status_ok: assert property (rspValid && cnt == 6'h01 |-> rspData == 8'h00)
		else $error("byte 1 is not zero");
	a_div_rsvd: assert property (rspValid && cnt == 6'h05 |-> rspData[7:5] == 3'h0)
		else $error("byte 5 top bits set");
	a_last_count: assert property (rspValid |-> rspLast == (cnt == 6'h3f))
		else $error("last flag misplaced");
	a_rsp_hold: assert property (rspValid && !rspReady |=> rspValid && $stable(rspData))
		else $error("response byte dropped");
	a_req_closed: assert property (rspValid |-> !reqReady)
		else $error("request open during response");
	a_rsp_done: assert property (take && rspLast |=> !rspValid && reqReady)
		else $error("no return to request");
	a_rx_follow: assert property ($rose(activity.uartRx) && awready |=>
		rxActivityIndicator != $past(rxActivityIndicator))
		else $error("rx indicator did not flip");
	a_tx_follow: assert property ($rose(activity.uartTx) && awready |=>
		txActivityIndicator != $past(txActivityIndicator))
		else $error("tx indicator did not flip");
	c_report: cover property (take && rspLast);
	c_stall: cover property (rspValid && !rspReady);
	c_rx: cover property ($rose(activity.uartRx));
endmodule : rsr_readback_chk
bind rsr_readback rsr_readback_chk rsr_readback_chk_i (.clk, .resetn, .awready, .reqReady, .rspValid,
	.rspData, .rspLast, .rspReady, .activity, .rxActivityIndicator, .txActivityIndicator);
`default_nettype wire

//--- verif/tb.sv
// Purpose: self-checking bench of the readback block
// Assumes: host model on the report streams
// Notes: AXI4-Lite master tasks
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) numChecks++; if ((a) !== (e)) begin fails++; $display("CHECK FAILED %s exp %h got %h", n, e, a); end
module tb
	import rsr_pkg::*;
;
	// ****
	// harness
	// ****
	logic clk, resetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf;
	rsr_activity_t activity = 5'h00;
	wire logic awready, wready, bvalid, arready, rvalid, reqValid, reqLast, reqReady, rspValid, rspLast, rspReady;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	wire logic [7:0] reqData, rspData;
	wire logic serialNumberEnable, rxActivityIndicator, txActivityIndicator, twowireActivityIndicator;
	wire logic suspendIndicator, configuredIndicator, generalPurposePinClock;
	wire logic [4:0] ind = {rxActivityIndicator, txActivityIndicator, twowireActivityIndicator,
		suspendIndicator, configuredIndicator};
	int fails = 0, numChecks = 0, cyc = 0;
	logic [1:0] bRsp = 2'b00;
	rsr_readback rsr_readback_i (.clk, .resetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .reqValid,
		.reqData, .reqLast, .reqReady, .rspValid, .rspData, .rspLast, .rspReady, .activity, .serialNumberEnable,
		.rxActivityIndicator, .txActivityIndicator, .twowireActivityIndicator, .suspendIndicator,
		.configuredIndicator, .generalPurposePinClock);
	rsr_host_model host_i (.clk, .reqReady, .reqValid, .reqData, .reqLast, .rspValid, .rspData, .rspLast,
		.rspReady);
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bRsp = bresp;
		bready <= 1'b0;
		@(posedge clk);
	endtask : axw
	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge clk);
	endtask : axr
	task automatic get_report();
		int n0;
		n0 = host_i.nGot;
		host_i.send(8'h61, 64);
		while (host_i.nGot < n0 + 64) @(posedge clk);
	endtask : get_report
	// ****
	// scenarios
	// ****
	task automatic t_regs();
		logic [31:0] d;
		logic [1:0] r;
		for (int i = 0; i < 5; i++) begin
			axr(8'(4 * i), d, r);
			`CHK("reset word", 32'h0, d)
		end
		axr(8'h14, d, r);
		`CHK("unmapped resp", 2'b10, r)
		axw(8'h14, 32'h0);
		`CHK("unmapped write", 2'b10, bRsp)
		$display("t_regs done");
	endtask : t_regs
	task automatic t_report();
		logic [7:0] f;
		logic [31:0] d;
		logic [1:0] r;
		axw(8'h04, 32'hff);
		axw(8'h08, 32'h0c22);
		axr(8'h08, d, r);
		`CHK("lengths word", 32'h00000c22, d)
		for (int p = 0; p < 3; p++) begin
			f = {p[0], 5'b01011, p[1:0]};
			axw(8'h00, {24'h0, f});
			host_i.slow = p[0];
			get_report();
			`CHK("echo", 8'h61, host_i.got[0])
			`CHK("status", 8'h00, host_i.got[1])
			`CHK("chip len", 8'h22, host_i.got[2])
			`CHK("pin len", 8'h0c, host_i.got[3])
			`CHK("flags", f, host_i.got[4])
			`CHK("clkdiv", 8'h1f, host_i.got[5])
			`CHK("pad", 8'h00, host_i.got[63])
			`CHK("serial en", p[0], serialNumberEnable)
		end
		$display("t_report done");
	endtask : t_report
	task automatic t_ind();
		logic [31:0] d;
		logic [1:0] r;
		axw(8'h00, 32'h7c);
		axw(8'h0c, 32'he);
		repeat (2) @(posedge clk);
		`CHK("ind idle", 5'h1f, ind)
		axr(8'h10, d, r);
		`CHK("status word", 32'h0000007c, d)
		activity <= 5'h1f;
		repeat (2) @(posedge clk);
		`CHK("ind busy", 5'h00, ind)
		axw(8'h0c, 32'h0);
		repeat (2) @(posedge clk);
		`CHK("ind off", 5'h07, ind)
		activity <= 5'h00;
		$display("t_ind done");
	endtask : t_ind
	task automatic t_clk();
		logic [4:0] tbl [4] = '{5'h08, 5'h00, 5'h19, 5'h12};
		int per, hi;
		logic [9:0] n;
		axw(8'h0c, 32'h1);
		for (int k = 0; k < 5; k++) begin
			per = (k < 4) ? 4 << tbl[k][2:0] : 16;
			hi = (k == 4) ? 0 : (tbl[k][4:3] == 2'b01) ? per / 4 : (tbl[k][4:3] == 2'b11) ? 3 * per / 4 : per / 2;
			if (k < 4) axw(8'h04, {27'h0, tbl[k]});
			else axw(8'h0c, 32'h0);
			repeat (per) @(posedge clk);
			n = 10'h000;
			repeat (2 * per) begin
				@(posedge clk);
				n += generalPurposePinClock;
			end
			`CHK("clock highs", 10'(2 * hi), n)
		end
		$display("t_clk done");
	endtask : t_clk
	task automatic t_refuse();
		int n0;
		n0 = host_i.nGot;
		host_i.send(8'h62, 64);
		host_i.send(8'h61, 10);
		host_i.send(8'h61, 54);
		repeat (100) @(posedge clk);
		`CHK("no response", n0, host_i.nGot)
		get_report();
		`CHK("one report", n0 + 64, host_i.nGot)
		$display("t_refuse done");
	endtask : t_refuse
	task automatic report_and_stop();
		$display("checks %0d fails %0d", numChecks, fails);
		if (fails == 0 && numChecks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : report_and_stop
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			report_and_stop();
		end
	end
	initial begin
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		t_regs();
		t_report();
		t_ind();
		t_clk();
		t_refuse();
		report_and_stop();
	end
endmodule : tb
`default_nettype wire
